//--- logic/lcsc_pkg.sv
// Package: constants for the charger state control block
package lcsc_pkg;
  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CHARGE_GO = 8'h20;
  localparam logic [7:0] ADDR_ILIM      = 8'h21;
  localparam logic [7:0] ADDR_ICHG      = 8'h22;
  localparam logic [7:0] ADDR_TSET      = 8'h23;
  localparam logic [7:0] ADDR_SUSPEND   = 8'h25;
  localparam logic [7:0] ADDR_STATE     = 8'h26;
  localparam logic [7:0] ADDR_IRQ_EN    = 8'h28;
  localparam logic [7:0] ADDR_IRQ_FLAG  = 8'h29;
  localparam logic [7:0] ADDR_IRQ_MON   = 8'h2A;
  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int          ILIM_LSB       = 1;
  localparam int          ICHG_LSB       = 1;
  localparam int          TEMP_LSB       = 4;
  localparam int          RTIM_LSB       = 2;
  localparam int          STATE_LSB      = 1;
  localparam logic [3:0]  ILIM_RST       = 4'h5;
  localparam logic [3:0]  ILIM_MAX       = 4'h9;
  localparam logic [3:0]  ICHG_RST       = 4'h4;
  localparam logic [3:0]  ICHG_MAX       = 4'h8;
  localparam logic [3:0]  ICHG_TRICKLE   = 4'h0;
  localparam logic [3:0]  ICHG_LOWEST    = 4'h0;
  localparam logic [1:0]  TEMP_RST       = 2'h2;
  localparam logic [1:0]  RTIM_RST       = 2'h0;
  localparam int          IRQ_NUM        = 10;
  localparam logic [9:0]  IRQ_EN_RST     = 10'h001;
  // Request bit order
  localparam int IRQ_ADAPTER  = 0;
  localparam int IRQ_DIE      = 1;
  localparam int IRQ_BTEMP    = 2;
  localparam int IRQ_ABSENT   = 3;
  localparam int IRQ_AOV      = 4;
  localparam int IRQ_BOV      = 5;
  localparam int IRQ_READY    = 6;
  localparam int IRQ_RAPID    = 7;
  localparam int IRQ_DONE     = 8;
  localparam int IRQ_TIMEOUT  = 9;
  localparam logic [9:0] IRQ_LEVEL_MASK = 10'h00E;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam longint CLK_HZ           = 250_000_000;
  localparam longint TRICKLE_MIN      = 40;
  localparam longint RAPID_MIN        = 120;
  localparam longint TRICKLE_CYC      = TRICKLE_MIN * 60 * CLK_HZ;
  localparam longint RAPID_CYC        = RAPID_MIN * 60 * CLK_HZ;
  localparam real    BLINK_HZ         = 1.5;
  localparam longint BLINK_HALF_CYC   = longint'(CLK_HZ / (2.0 * BLINK_HZ));
  localparam longint STEP_US          = 10;
  localparam longint STEP_CYC         = STEP_US * CLK_HZ / 1_000_000;
  // ---------------------------------------------------------------
  // States
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_OFF, ST_READY, ST_SUSPEND, ST_TRICKLE, ST_RAPID, ST_DONE,
    ST_BATT_ERR, ST_NO_BATT, ST_AOV, ST_BOV, ST_BTEMP
  } lcsc_state_type;
endpackage

//--- logic/lcsc_top.sv
// Charger state control: state machine, path control, indicator, requests
`timescale 1ns/1ps
`default_nettype none
module lcsc_top #(
  parameter longint TRICKLE_CYCLES = lcsc_pkg::TRICKLE_CYC,
  parameter longint RAPID_CYCLES   = lcsc_pkg::RAPID_CYC,
  parameter longint BLINK_CYCLES   = lcsc_pkg::BLINK_HALF_CYC,
  parameter longint STEP_CYCLES    = lcsc_pkg::STEP_CYC
) (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       adapter_above_4v3,
  input  wire logic       adapter_above_6v2,
  input  wire logic       adapter_above_4v0,
  input  wire logic       batt_above_3v0,
  input  wire logic       batt_above_4v0,
  input  wire logic       batt_above_4v1,
  input  wire logic       batt_above_4v6,
  input  wire logic       batt_absent,
  input  wire logic       therm_above_73,
  input  wire logic       therm_below_23,
  input  wire logic       die_overheat,
  input  wire logic       total_over_limit,
  input  wire logic       chg_below_comp,
  output logic            adapter_path_switch,
  output logic            battery_path_switch,
  output logic            charge_enable,
  output logic      [3:0] charge_current_cmd,
  output logic      [3:0] current_limit_cmd,
  output logic      [1:0] die_temp_setting,
  output logic            charge_indicator_out,
  output logic            charge_indicator_oe,
  output logic            irq_out_n
);
  localparam int NIN = 13;

  typedef struct packed {
    logic [NIN-1:0]          s1;
    logic [NIN-1:0]          s2;
    logic [NIN-1:0]          s3;
    logic [NIN-1:0]          in;
    lcsc_pkg::lcsc_state_type st;
    lcsc_pkg::lcsc_state_type prev;
    logic                    charge_go;
    logic                    suspend_rel;
    logic [3:0]              ilim;
    logic [3:0]              ichg_set;
    logic [1:0]              temp_set;
    logic [1:0]              rtim_set;
    logic [9:0]              irq_en;
    logic [9:0]              irq_flag;
    logic [3:0]              ichg_cur;
    logic [40:0]             timer;
    logic [31:0]             blink_cnt;
    logic [31:0]             step_cnt;
    logic                    blink;
    logic [7:0]              rdata;
    logic                    asw;
    logic                    bsw;
    logic                    chg_en;
    logic                    led_oe;
    logic                    irq_n;
  } lcsc_regs_type;

  lcsc_regs_type r, n;
  logic [NIN-1:0] raw;
  logic           adp_ok, aov, babs, bov, btemp, die, v30, v40, v41, a40, over, below;
  logic           charging, flt;
  logic [9:0]     ev;

  assign raw = {chg_below_comp, total_over_limit, die_overheat, therm_below_23, therm_above_73,
                batt_absent, batt_above_4v6, batt_above_4v1, batt_above_4v0, batt_above_3v0,
                adapter_above_4v0, adapter_above_6v2, adapter_above_4v3};

  // -------------------------------------------------------------
  // Next state
  // -------------------------------------------------------------
  always_comb begin
    n = r;
    n.s1 = raw;
    n.s2 = r.s1;
    n.s3 = r.s2;
    // Input changes count only once two later stages agree
    for (int i = 0; i < NIN; i++) begin
      if (r.s2[i] == r.s3[i]) begin
        n.in[i] = r.s3[i];
      end
    end
    adp_ok = r.in[0] && !r.in[1];
    aov    = r.in[1];
    a40    = r.in[2];
    v30    = r.in[3];
    v40    = r.in[4];
    v41    = r.in[5];
    bov    = r.in[6];
    babs   = r.in[7];
    btemp  = r.in[8] || r.in[9];
    die    = r.in[10];
    over   = r.in[11];
    below  = r.in[12];
    flt    = bov || babs || btemp || (r.st == lcsc_pkg::ST_BATT_ERR);
    ev     = '0;
    n.rdata = 8'h00;

    // Register writes
    if (reg_wr) begin
      unique case (reg_addr)
        lcsc_pkg::ADDR_CHARGE_GO: n.charge_go = reg_wdata[0];
        lcsc_pkg::ADDR_ILIM: begin
          // Out-of-range codes clamp to the 1200 mA step
          if (reg_wdata[lcsc_pkg::ILIM_LSB +: 4] > lcsc_pkg::ILIM_MAX) begin
            n.ilim = lcsc_pkg::ILIM_MAX;
          end else begin
            n.ilim = reg_wdata[lcsc_pkg::ILIM_LSB +: 4];
          end
        end
        lcsc_pkg::ADDR_ICHG: begin
          if (reg_wdata[lcsc_pkg::ICHG_LSB +: 4] > lcsc_pkg::ICHG_MAX) begin
            n.ichg_set = lcsc_pkg::ICHG_MAX;
          end else begin
            n.ichg_set = reg_wdata[lcsc_pkg::ICHG_LSB +: 4];
          end
        end
        lcsc_pkg::ADDR_TSET: begin
          n.temp_set = reg_wdata[lcsc_pkg::TEMP_LSB +: 2];
          n.rtim_set = reg_wdata[lcsc_pkg::RTIM_LSB +: 2];
        end
        lcsc_pkg::ADDR_SUSPEND: n.suspend_rel = reg_wdata[0];
        lcsc_pkg::ADDR_IRQ_EN: n.irq_en = {reg_wdata[1:0], reg_wdata};
        lcsc_pkg::ADDR_IRQ_FLAG: n.irq_flag = r.irq_flag & ~({2'b00, reg_wdata});
        default: ;
      endcase
    end

    // State machine; protective states take priority
    unique case (r.st)
      lcsc_pkg::ST_OFF: begin
        if (adp_ok) begin
          n.st = lcsc_pkg::ST_READY;
        end
      end
      lcsc_pkg::ST_READY: begin
        if (!r.suspend_rel) begin
          n.st = lcsc_pkg::ST_SUSPEND;
        end else if (r.charge_go) begin
          n.st = lcsc_pkg::ST_TRICKLE;
        end
      end
      lcsc_pkg::ST_SUSPEND: begin
        if (r.suspend_rel) begin
          n.st = lcsc_pkg::ST_READY;
        end
      end
      lcsc_pkg::ST_TRICKLE: begin
        if (!r.suspend_rel) begin
          n.st = lcsc_pkg::ST_SUSPEND;
        end else if (!r.charge_go) begin
          n.st = lcsc_pkg::ST_READY;
        end else if (r.timer >= 41'(TRICKLE_CYCLES - 1)) begin
          n.st = lcsc_pkg::ST_BATT_ERR;
          ev[lcsc_pkg::IRQ_TIMEOUT] = 1'b1;
        end else if (v30) begin
          n.st = lcsc_pkg::ST_RAPID;
        end
      end
      lcsc_pkg::ST_RAPID: begin
        if (!r.suspend_rel) begin
          n.st = lcsc_pkg::ST_SUSPEND;
        end else if (!r.charge_go) begin
          n.st = lcsc_pkg::ST_READY;
        end else if (!v30) begin
          n.st = lcsc_pkg::ST_TRICKLE;
        end else if (below && v41 && !die) begin
          n.st = lcsc_pkg::ST_DONE;
        end else if (r.timer >= 41'(RAPID_CYCLES - 1)) begin
          n.st = lcsc_pkg::ST_DONE;
          ev[lcsc_pkg::IRQ_TIMEOUT] = 1'b1;
        end
      end
      lcsc_pkg::ST_DONE: begin
        if (!r.suspend_rel) begin
          n.st = lcsc_pkg::ST_SUSPEND;
        end else if (!r.charge_go) begin
          n.st = lcsc_pkg::ST_READY;
        end else if (!v40) begin
          n.st = lcsc_pkg::ST_RAPID;
        end
      end
      lcsc_pkg::ST_BATT_ERR: ;
      lcsc_pkg::ST_NO_BATT: begin
        if (!babs) begin
          n.st = lcsc_pkg::ST_READY;
        end
      end
      lcsc_pkg::ST_AOV: begin
        if (!a40) begin
          n.st = lcsc_pkg::ST_OFF;
        end
      end
      lcsc_pkg::ST_BOV: begin
        if (babs) begin
          n.st = lcsc_pkg::ST_NO_BATT;
        end
      end
      lcsc_pkg::ST_BTEMP: begin
        if (!btemp) begin
          n.st = r.prev;
        end
      end
      default: n.st = lcsc_pkg::ST_OFF;
    endcase

    // Protective entries, highest first
    if (aov) begin
      n.st = lcsc_pkg::ST_AOV;
    end else if (r.st != lcsc_pkg::ST_AOV) begin
      if (r.st != lcsc_pkg::ST_OFF && bov) begin
        n.st = lcsc_pkg::ST_BOV;
      end else if (r.st != lcsc_pkg::ST_OFF && babs && r.st != lcsc_pkg::ST_BOV) begin
        n.st = lcsc_pkg::ST_NO_BATT;
      end else if (btemp && r.st != lcsc_pkg::ST_BTEMP && r.st != lcsc_pkg::ST_OFF &&
                   r.st != lcsc_pkg::ST_BOV && r.st != lcsc_pkg::ST_NO_BATT) begin
        n.st = lcsc_pkg::ST_BTEMP;
        n.prev = r.st;
      end else if (!r.in[0] && r.st != lcsc_pkg::ST_BTEMP) begin
        n.st = lcsc_pkg::ST_OFF;
      end
    end

    // Suspend bit forcing
    if (!(r.st inside {lcsc_pkg::ST_OFF, lcsc_pkg::ST_AOV, lcsc_pkg::ST_SUSPEND,
          lcsc_pkg::ST_READY, lcsc_pkg::ST_TRICKLE, lcsc_pkg::ST_RAPID, lcsc_pkg::ST_DONE})) begin
      n.suspend_rel = 1'b1;
    end
    if (r.st == lcsc_pkg::ST_AOV && flt) begin
      n.suspend_rel = 1'b1;
    end

    // Timers restart on entry, clear on leaving
    if (n.st != r.st || !(r.st inside {lcsc_pkg::ST_TRICKLE, lcsc_pkg::ST_RAPID})) begin
      n.timer = '0;
    end else begin
      n.timer = r.timer + 41'h1;
    end

    // Current command
    charging = (r.st inside {lcsc_pkg::ST_TRICKLE, lcsc_pkg::ST_RAPID}) && adp_ok;
    n.step_cnt = (r.step_cnt >= 32'(STEP_CYCLES - 1)) ? 32'h0 : r.step_cnt + 32'h1;
    if (!charging) begin
      n.ichg_cur = lcsc_pkg::ICHG_LOWEST;
    end else if (die) begin
      n.ichg_cur = lcsc_pkg::ICHG_LOWEST;
    end else if (r.st == lcsc_pkg::ST_TRICKLE) begin
      n.ichg_cur = lcsc_pkg::ICHG_TRICKLE;
    end else if (over) begin
      n.ichg_cur = (r.ichg_cur == 4'h0) ? 4'h0 : r.ichg_cur - 4'h1;
    end else if (r.step_cnt == 32'h0 && r.ichg_cur < r.ichg_set) begin
      n.ichg_cur = r.ichg_cur + 4'h1;
    end else if (r.ichg_cur > r.ichg_set) begin
      n.ichg_cur = r.ichg_set;
    end

    // Power path
    n.chg_en = charging;
    unique case (r.st)
      lcsc_pkg::ST_DONE, lcsc_pkg::ST_NO_BATT, lcsc_pkg::ST_BOV, lcsc_pkg::ST_BTEMP,
      lcsc_pkg::ST_BATT_ERR: begin
        n.asw = 1'b1;
        n.bsw = 1'b0;
      end
      lcsc_pkg::ST_AOV: begin
        n.asw = flt;
        n.bsw = !flt;
      end
      lcsc_pkg::ST_OFF, lcsc_pkg::ST_SUSPEND: begin
        n.asw = 1'b0;
        n.bsw = 1'b1;
      end
      default: begin
        n.asw = adp_ok;
        n.bsw = 1'b1;
      end
    endcase

    // Indicator: drive low means lit
    if (r.blink_cnt >= 32'(BLINK_CYCLES - 1)) begin
      n.blink_cnt = 32'h0;
      n.blink = !r.blink;
    end else begin
      n.blink_cnt = r.blink_cnt + 32'h1;
    end
    unique case (r.st)
      lcsc_pkg::ST_RAPID: n.led_oe = 1'b1;
      lcsc_pkg::ST_OFF, lcsc_pkg::ST_READY, lcsc_pkg::ST_SUSPEND, lcsc_pkg::ST_DONE:
        n.led_oe = 1'b0;
      default: n.led_oe = r.blink;
    endcase

    // Requests: events latch, set wins over clear
    ev[lcsc_pkg::IRQ_ADAPTER] = n.in[0] != r.in[0];
    ev[lcsc_pkg::IRQ_AOV]     = n.in[1] && !r.in[1];
    ev[lcsc_pkg::IRQ_BOV]     = n.in[6] && !r.in[6];
    ev[lcsc_pkg::IRQ_READY]   = n.st == lcsc_pkg::ST_READY && r.st != lcsc_pkg::ST_READY;
    ev[lcsc_pkg::IRQ_RAPID]   = n.st == lcsc_pkg::ST_RAPID && r.st != lcsc_pkg::ST_RAPID;
    ev[lcsc_pkg::IRQ_DONE]    = n.st == lcsc_pkg::ST_DONE && r.st != lcsc_pkg::ST_DONE;
    n.irq_flag = (n.irq_flag & ~lcsc_pkg::IRQ_LEVEL_MASK) | ev;
    n.irq_flag[lcsc_pkg::IRQ_DIE]    = die;
    n.irq_flag[lcsc_pkg::IRQ_BTEMP]  = btemp;
    n.irq_flag[lcsc_pkg::IRQ_ABSENT] = babs;
    n.irq_n = ~|(r.irq_flag & r.irq_en);

    // Register reads
    if (reg_rd) begin
      unique case (reg_addr)
        lcsc_pkg::ADDR_CHARGE_GO: n.rdata = {7'h00, r.charge_go};
        lcsc_pkg::ADDR_ILIM:      n.rdata = {3'h0, r.ilim, 1'b0};
        lcsc_pkg::ADDR_ICHG:      n.rdata = {3'h0, r.ichg_set, 1'b0};
        lcsc_pkg::ADDR_TSET:      n.rdata = {2'h0, r.temp_set, 2'h0 , 2'h0} |
                                            {4'h0, r.rtim_set, 2'h0};
        lcsc_pkg::ADDR_SUSPEND:   n.rdata = {7'h00, r.suspend_rel};
        lcsc_pkg::ADDR_STATE:     n.rdata = {3'h0, r.st, 1'b0};
        lcsc_pkg::ADDR_IRQ_EN:    n.rdata = r.irq_en[7:0];
        lcsc_pkg::ADDR_IRQ_FLAG:  n.rdata = r.irq_flag[7:0];
        lcsc_pkg::ADDR_IRQ_MON:   n.rdata = {r.irq_flag[9:8], r.irq_en[9:8], 4'h0};
        default:                  n.rdata = 8'h00;
      endcase
    end
  end

  // -------------------------------------------------------------
  // State register
  // -------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      r             <= '0;
      r.st          <= lcsc_pkg::ST_OFF;
      r.prev        <= lcsc_pkg::ST_OFF;
      r.charge_go   <= 1'b1;
      r.suspend_rel <= 1'b1;
      r.ilim        <= lcsc_pkg::ILIM_RST;
      r.ichg_set    <= lcsc_pkg::ICHG_RST;
      r.temp_set    <= lcsc_pkg::TEMP_RST;
      r.rtim_set    <= lcsc_pkg::RTIM_RST;
      r.irq_en      <= lcsc_pkg::IRQ_EN_RST;
      r.bsw         <= 1'b1;
      r.irq_n       <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign reg_rdata            = r.rdata;
  assign adapter_path_switch  = r.asw;
  assign battery_path_switch  = r.bsw;
  assign charge_enable        = r.chg_en;
  assign charge_current_cmd   = r.ichg_cur;
  assign current_limit_cmd    = r.ilim;
  assign die_temp_setting     = r.temp_set;
  assign charge_indicator_out = 1'b0;
  assign charge_indicator_oe  = r.led_oe;
  assign irq_out_n            = r.irq_n;

  // -------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------
  property p_trickle_cur;
    @(posedge sys_clk) disable iff (rst)
      (r.st == lcsc_pkg::ST_TRICKLE) |=> (r.ichg_cur == lcsc_pkg::ICHG_TRICKLE);
  endproperty
  a_trickle_cur: assert property (p_trickle_cur) else $error("trickle current high");

  property p_irq;
    @(posedge sys_clk) disable iff (rst)
      (|(r.irq_flag & r.irq_en)) |=> !irq_out_n;
  endproperty
  a_irq: assert property (p_irq) else $error("irq not asserted");

  property p_aov;
    @(posedge sys_clk) disable iff (rst) aov |=> (r.st == lcsc_pkg::ST_AOV);
  endproperty
  a_aov: assert property (p_aov) else $error("adapter overvolt missed");

  property p_susp_force;
    @(posedge sys_clk) disable iff (rst)
      (r.st inside {lcsc_pkg::ST_BOV, lcsc_pkg::ST_NO_BATT, lcsc_pkg::ST_BATT_ERR,
                    lcsc_pkg::ST_BTEMP}) |=> r.suspend_rel;
  endproperty
  a_susp_force: assert property (p_susp_force) else $error("suspend bit not forced");

  property p_led_rapid;
    @(posedge sys_clk) disable iff (rst)
      (r.st == lcsc_pkg::ST_RAPID) [*2] |-> charge_indicator_oe;
  endproperty
  a_led_rapid: assert property (p_led_rapid) else $error("indicator off in rapid");

  property p_die;
    @(posedge sys_clk) disable iff (rst) die |=> (r.ichg_cur == lcsc_pkg::ICHG_LOWEST);
  endproperty
  a_die: assert property (p_die) else $error("overheat current not lowest");

  property p_done_path;
    @(posedge sys_clk) disable iff (rst)
      (r.st == lcsc_pkg::ST_DONE) [*2] |-> (adapter_path_switch && !battery_path_switch);
  endproperty
  a_done_path: assert property (p_done_path) else $error("done path wrong");

  property p_timer;
    @(posedge sys_clk) disable iff (rst)
      !(r.st inside {lcsc_pkg::ST_TRICKLE, lcsc_pkg::ST_RAPID}) |=> (r.timer == 41'h0);
  endproperty
  a_timer: assert property (p_timer) else $error("timer not cleared");
endmodule // lcsc_top
`default_nettype wire

//--- tb/lcsc_far_model.sv
// Far-side model: adapter, battery with thermistor, and charge path
`timescale 1ns/1ps
`default_nettype none
module lcsc_far_model (
  input  wire logic [12:0] adapter_mv,
  input  wire logic [12:0] batt_mv,
  input  wire logic [6:0]  therm_pct,
  input  wire logic        charge_enable,
  output logic             adapter_above_4v3,
  output logic             adapter_above_6v2,
  output logic             adapter_above_4v0,
  output logic             batt_above_3v0,
  output logic             batt_above_4v0,
  output logic             batt_above_4v1,
  output logic             batt_above_4v6,
  output logic             batt_absent,
  output logic             therm_above_73,
  output logic             therm_below_23,
  output logic             chg_below_comp
);
  // ---------------------------------------------------------------
  // Comparators, voltage thresholds in millivolts, thermistor thresholds in percent
  // ---------------------------------------------------------------
  assign adapter_above_4v3 = adapter_mv > 13'h10CC;
  assign adapter_above_6v2 = adapter_mv > 13'h1838;
  assign adapter_above_4v0 = adapter_mv > 13'h0FA0;
  assign batt_above_3v0    = batt_mv > 13'h0BB8;
  assign batt_above_4v0    = batt_mv > 13'h0FA0;
  assign batt_above_4v1    = batt_mv > 13'h1004;
  assign batt_above_4v6    = batt_mv > 13'h11F8;
  // Zero millivolts stands for a pulled battery
  assign batt_absent       = batt_mv == 13'h0000;
  assign therm_above_73    = therm_pct > 7'h49;
  assign therm_below_23    = therm_pct < 7'h17;
  // Taper current near full charge, and whenever charge_enable is low
  assign chg_below_comp    = !charge_enable || batt_mv > 13'h1036;
endmodule // lcsc_far_model
`default_nettype wire

//--- tb/testbench.sv
// Testbench for the charger state control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin fail_count++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module testbench;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, rd_d;
  logic        reg_wr = 1'b0, reg_rd = 1'b0, die_overheat = 1'b0, total_over_limit = 1'b0;
  logic [12:0] adapter_mv = 13'h0000, batt_mv = 13'h0E10;
  logic [6:0]  therm_pct = 7'h32;
  int          fail_count = 0, total_checks = 0, cyc = 0;
  wire logic [7:0] reg_rdata;
  wire logic [3:0] charge_current_cmd, current_limit_cmd;
  wire logic [1:0] die_temp_setting;
  wire logic       adapter_above_4v3, adapter_above_6v2, adapter_above_4v0, batt_above_3v0;
  wire logic       batt_above_4v0, batt_above_4v1, batt_above_4v6, batt_absent, chg_below_comp;
  wire logic       therm_above_73, therm_below_23, adapter_path_switch, battery_path_switch;
  wire logic       charge_enable, charge_indicator_out, charge_indicator_oe, irq_out_n;
  always #2 sys_clk = ~sys_clk;
  lcsc_top #(.TRICKLE_CYCLES(60), .RAPID_CYCLES(400), .BLINK_CYCLES(4), .STEP_CYCLES(2))
  u_lcsc_top (.sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .adapter_above_4v3, .adapter_above_6v2, .adapter_above_4v0, .batt_above_3v0,
    .batt_above_4v0, .batt_above_4v1, .batt_above_4v6, .batt_absent, .therm_above_73,
    .therm_below_23, .die_overheat, .total_over_limit, .chg_below_comp,
    .adapter_path_switch, .battery_path_switch, .charge_enable, .charge_current_cmd,
    .current_limit_cmd, .die_temp_setting, .charge_indicator_out, .charge_indicator_oe,
    .irq_out_n);
  lcsc_far_model u_lcsc_far_model (.adapter_mv, .batt_mv, .therm_pct, .charge_enable,
    .adapter_above_4v3, .adapter_above_6v2, .adapter_above_4v0, .batt_above_3v0,
    .batt_above_4v0, .batt_above_4v1, .batt_above_4v6, .batt_absent, .therm_above_73,
    .therm_below_23, .chg_below_comp);
  // ---------------------------------------------------------------
  // Register port tasks
  // ---------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    #1 rd_d = reg_rdata;
  endtask
  // Polls the state register, giving up after 80 reads
  task automatic wait_st(input lcsc_pkg::lcsc_state_type s);
    int n;
    for (n = 0; n < 80; n++) begin
      rd(lcsc_pkg::ADDR_STATE);
      if (rd_d === {3'h0, s, 1'b0}) break;
    end
    `CHK(rd_d, {3'h0, s, 1'b0})
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      test_done();
    end
  end
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    rd(lcsc_pkg::ADDR_ILIM);
    `CHK(rd_d, 8'h0A)
    `CHK(current_limit_cmd, lcsc_pkg::ILIM_RST)
    rd(8'h27);
    `CHK(rd_d, 8'h00)
    adapter_mv <= 13'h1388;
    wait_st(lcsc_pkg::ST_RAPID);
    `CHK(charge_indicator_oe, 1'b1)
    rd(lcsc_pkg::ADDR_IRQ_FLAG);
    `CHK(rd_d[lcsc_pkg::IRQ_RAPID], 1'b1)
    wr(lcsc_pkg::ADDR_CHARGE_GO, 8'h00);
    wait_st(lcsc_pkg::ST_READY);
    wr(lcsc_pkg::ADDR_SUSPEND, 8'h00);
    wait_st(lcsc_pkg::ST_SUSPEND);
    `CHK(charge_enable, 1'b0)
    wr(lcsc_pkg::ADDR_SUSPEND, 8'h01);
    wait_st(lcsc_pkg::ST_READY);
    wr(lcsc_pkg::ADDR_CHARGE_GO, 8'h01);
    wait_st(lcsc_pkg::ST_RAPID);
    die_overheat <= 1'b1;
    repeat (12) @(posedge sys_clk);
    `CHK(charge_current_cmd, lcsc_pkg::ICHG_LOWEST)
    die_overheat <= 1'b0;
    repeat (40) @(posedge sys_clk);
    `CHK(charge_current_cmd, lcsc_pkg::ICHG_RST)
    total_over_limit <= 1'b1;
    repeat (14) @(posedge sys_clk);
    `CHK(charge_current_cmd, lcsc_pkg::ICHG_LOWEST)
    total_over_limit <= 1'b0;
    therm_pct <= 7'h50;
    wait_st(lcsc_pkg::ST_BTEMP);
    `CHK({charge_enable, adapter_path_switch, battery_path_switch}, 3'h2)
    rd(lcsc_pkg::ADDR_IRQ_FLAG);
    `CHK(rd_d[lcsc_pkg::IRQ_BTEMP], 1'b1)
    therm_pct <= 7'h32;
    wait_st(lcsc_pkg::ST_RAPID);
    batt_mv <= 13'h1068;
    wait_st(lcsc_pkg::ST_DONE);
    `CHK({adapter_path_switch, battery_path_switch, charge_indicator_oe}, 3'h4)
    batt_mv <= 13'h0E10;
    wait_st(lcsc_pkg::ST_RAPID);
    batt_mv <= 13'h09C4;
    wait_st(lcsc_pkg::ST_TRICKLE);
    `CHK(charge_current_cmd, lcsc_pkg::ICHG_TRICKLE)
    wait_st(lcsc_pkg::ST_BATT_ERR);
    wr(lcsc_pkg::ADDR_SUSPEND, 8'h00);
    rd(lcsc_pkg::ADDR_SUSPEND);
    `CHK(rd_d, 8'h01)
    rd(lcsc_pkg::ADDR_IRQ_MON);
    `CHK(rd_d[7], 1'b1)
    wr(lcsc_pkg::ADDR_IRQ_EN, 8'h02);
    repeat (3) @(posedge sys_clk);
    `CHK(irq_out_n, 1'b0)
    wr(lcsc_pkg::ADDR_IRQ_EN, 8'h00);
    repeat (3) @(posedge sys_clk);
    `CHK(irq_out_n, 1'b1)
    adapter_mv <= 13'h1964;
    wait_st(lcsc_pkg::ST_AOV);
    `CHK({adapter_path_switch, battery_path_switch}, 2'h1)
    adapter_mv <= 13'h0F3C;
    wait_st(lcsc_pkg::ST_OFF);
    `CHK(charge_enable, 1'b0)
    test_done();
  end
endmodule // testbench
`default_nettype wire
